// ---- design/dofs_output_select.sv ----
// digital output function selector: condition vector and four terminals
//
// Contract
// - two relays, collector, fast terminal, own selects
// - fast terminal: pulse train or plain level
// - same code usable on several terminals
// - code zero keeps terminal off, except the fast terminal in pulse mode
// - codes 1-4 running, forward, reverse, jog
// - code 5 drive fault
// - code 9 output and reference both zero
// - codes 10, 11 upper, lower limit
// - code 12 powers ok, no protection, ready
// - code 13 during pre-excitation
// - codes 14, 15 overload, underload pre-alarm
// - codes 16, 17 sequencer stage, cycle done
// - codes 23,24,25,34 fieldbus virtual bits
// - code 26 bus above undervoltage
// - code 27 index pulse held 10 ms
// - code 28 pulse superposition active
// - code 29 safe torque off fault
// - codes 30-32 positioning, spindle zero, scale
// - code 33 frequency held at limit
// - code 36 speed/position switchover done
// - code 37 ramp reference above detect value
// - codes 41, 42 card collector outputs
`timescale 1ns/10ps
`include "dofs_defines.svh"
module dofs_output_select #(
    parameter int unsigned INDEX_HOLD_CYC = `DOFS_INDEX_HOLD_CYC
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic [`DOFS_SEL_W-1:0]     selRelay1,
    input  wire logic [`DOFS_SEL_W-1:0]     selRelay2,
    input  wire logic [`DOFS_SEL_W-1:0]     selCollector,
    input  wire logic [`DOFS_SEL_W-1:0]     selFast,
    input  wire logic                       fastPulseMode,
    input  wire logic                       fastPulseTrain,
    input  wire dofs_pkg::dofs_status_t     status,
    input  wire dofs_pkg::dofs_virt_t       virtBits,
    input  wire dofs_pkg::dofs_card_t       cardOut,
    input  wire logic                       encIndexPin,
    output logic                            relay1,
    output logic                            relay2,
    output logic                            collectorOut,
    output logic                            fast_pulse_terminal,
    output logic                            indexHoldActive
);

    // ****************************************************************
    // index pulse stretcher
    // ****************************************************************

    logic        indexSync;
    logic        indexPrev;
    logic        indexRise;
    logic [31:0] holdCount;
    logic [31:0] next_holdCount;

    // the index arrives from the encoder pin, outside our domain
    dofs_sync3 uIndexSync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     (encIndexPin),
        .dout    (indexSync)
    );

    assign indexRise = indexSync & ~indexPrev;
    // a new index restarts the window rather than being lost
    assign next_holdCount = indexRise ? INDEX_HOLD_CYC
                          : (holdCount != 32'h00000000) ? holdCount - 32'h00000001
                          : holdCount;

    // hold the level for the configured time after each index edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            indexPrev <= 1'b0;
            holdCount <= 32'h00000000;
        end else begin
            indexPrev <= indexSync;
            holdCount <= next_holdCount;
        end
    end

    assign indexHoldActive = (holdCount != 32'h00000000);

    // ****************************************************************
    // condition vector indexed by select code
    // ****************************************************************

    logic [`DOFS_COND_N-1:0] cond;
    logic [`DOFS_TERM_N-1:0] virtSel;

    // every unlisted code other than the virtual-bit codes 23, 24, 25, 34 is tied off so the terminal stays off
    always_comb begin
        cond     = '0;
        cond[0]  = 1'b0;
        cond[1]  = status.running;
        cond[2]  = status.fwdRunning;
        cond[3]  = status.revRunning;
        cond[4]  = status.jogging;
        cond[5]  = status.fault;
        cond[6]  = status.freqLevelDetectA;
        cond[7]  = status.freqLevelDetectB;
        cond[8]  = status.freqReached;
        cond[9]  = status.outFreqZero & status.refFreqZero;
        cond[10] = status.upperLimit;
        cond[11] = status.lowerLimit;
        cond[12] = status.mainPowerOk & status.ctrlPowerOk
                 & ~status.protectionActive & status.readyToRun;
        cond[13] = status.preExciting;
        cond[14] = status.overloadAlarm;
        cond[15] = status.underloadAlarm;
        cond[16] = status.stageDone;
        cond[17] = status.cycleDone;
        cond[26] = status.busAboveUv;
        cond[27] = indexHoldActive;
        cond[28] = status.pulseSuperpose;
        cond[29] = status.safeTorqueOffFault;
        cond[30] = status.positioningDone;
        cond[31] = status.spindleZeroDone;
        cond[32] = status.spindleScaleDone;
        cond[33] = status.speedLimited;
        cond[36] = status.modeSwitchDone;
        cond[37] = status.rampAboveDetect;
        cond[41] = cardOut.cardCollectorOutA;
        cond[42] = cardOut.cardCollectorOutB;
    end

    // ****************************************************************
    // terminals
    // ****************************************************************

    logic [`DOFS_SEL_W-1:0] sel    [`DOFS_TERM_N];
    logic [`DOFS_TERM_N-1:0] level;

    assign sel[`DOFS_TERM_RELAY1]    = selRelay1;
    assign sel[`DOFS_TERM_RELAY2]    = selRelay2;
    assign sel[`DOFS_TERM_COLLECTOR] = selCollector;
    assign sel[`DOFS_TERM_FAST]      = selFast;

    // virtual bits differ per terminal, so each gets its own vector
    genvar t;
    generate
        for (t = 0; t < `DOFS_TERM_N; t++) begin : g_term
            logic [`DOFS_COND_N-1:0] termCond;
            always_comb begin
                termCond     = cond;
                termCond[23] = virtBits.modbus[t];
                termCond[24] = virtBits.fieldbusA[t];
                termCond[25] = virtBits.ethernet[t];
                termCond[34] = virtBits.realtimeEth[t];
            end
            dofs_term_mux uMux (
                .clk_sys (clk_sys),
                .rst     (rst),
                .sel     (sel[t]),
                .cond    (termCond),
                .level   (level[t])
            );
        end
    endgenerate

    assign virtSel = level;

    // fast terminal forwards the pulse generator when in pulse mode
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fast_pulse_terminal <= 1'b0;
        end else begin
            fast_pulse_terminal <= fastPulseMode ? fastPulseTrain
                                 : level[`DOFS_TERM_FAST];
        end
    end

    assign relay1       = virtSel[`DOFS_TERM_RELAY1];
    assign relay2       = virtSel[`DOFS_TERM_RELAY2];
    assign collectorOut = virtSel[`DOFS_TERM_COLLECTOR];

endmodule : dofs_output_select

// ---- design/dofs_sync3.sv ----
// three-stage input synchroniser with agreement on the last two stages
`timescale 1ns/10ps
module dofs_sync3 (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    logic s1;
    logic s2;
    logic s3;

    // s1 is read only by s2 to keep metastability contained
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s1   <= 1'b0;
            s2   <= 1'b0;
            s3   <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule : dofs_sync3

// ---- design/dofs_term_mux.sv ----
// one output terminal: select code to registered level
`timescale 1ns/10ps
`include "dofs_defines.svh"
module dofs_term_mux (
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic [`DOFS_SEL_W-1:0]     sel,
    input  wire logic [`DOFS_COND_N-1:0]    cond,
    output logic                            level
);
    logic next_level;

    // code zero and unused codes see a zero entry in the vector
    assign next_level = (sel == `DOFS_SEL_OFF) ? 1'b0 : cond[sel];

    // registered so the pin does not glitch while the select changes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            level <= 1'b0;
        end else begin
            level <= next_level;
        end
    end
endmodule : dofs_term_mux

// ---- include/dofs_defines.svh ----
// timing counts and select codes for the digital output function selector
`ifndef DOFS_DEFINES_SVH
`define DOFS_DEFINES_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define DOFS_CLK_HZ          50000000
`define DOFS_INDEX_HOLD_MS   10
`define DOFS_INDEX_HOLD_CYC  ((`DOFS_CLK_HZ / 1000) * `DOFS_INDEX_HOLD_MS)

// ****************************************************************
// select code layout
// ****************************************************************
`define DOFS_SEL_W           6
`define DOFS_COND_N          64
`define DOFS_SEL_OFF         6'h00
`define DOFS_TERM_N          4
`define DOFS_TERM_RELAY1     0
`define DOFS_TERM_RELAY2     1
`define DOFS_TERM_COLLECTOR  2
`define DOFS_TERM_FAST       3

// ****************************************************************
// reset values of the selects
// ****************************************************************
`define DOFS_RST_RELAY1      6'h01
`define DOFS_RST_RELAY2      6'h05
`define DOFS_RST_OTHER       6'h00

`endif

// ---- include/dofs_pkg.sv ----
// shared types of the digital output function selector
package dofs_pkg;

    // per-condition live inputs, grouped by origin
    typedef struct packed {
        logic running;
        logic fwdRunning;
        logic revRunning;
        logic jogging;
        logic fault;
        logic freqLevelDetectA;
        logic freqLevelDetectB;
        logic freqReached;
        logic outFreqZero;
        logic refFreqZero;
        logic upperLimit;
        logic lowerLimit;
        logic mainPowerOk;
        logic ctrlPowerOk;
        logic protectionActive;
        logic readyToRun;
        logic preExciting;
        logic overloadAlarm;
        logic underloadAlarm;
        logic stageDone;
        logic cycleDone;
        logic busAboveUv;
        logic pulseSuperpose;
        logic safeTorqueOffFault;
        logic positioningDone;
        logic spindleZeroDone;
        logic spindleScaleDone;
        logic speedLimited;
        logic modeSwitchDone;
        logic rampAboveDetect;
    } dofs_status_t;

    // fieldbus virtual bits, one per terminal
    typedef struct packed {
        logic [3:0] modbus;
        logic [3:0] fieldbusA;
        logic [3:0] ethernet;
        logic [3:0] realtimeEth;
    } dofs_virt_t;

    // programmable card collector outputs
    typedef struct packed {
        logic cardCollectorOutA;
        logic cardCollectorOutB;
    } dofs_card_t;

endpackage : dofs_pkg

// ---- tb/dofs_output_select_bench.sv ----
// self-checking bench for the digital output function selector
`timescale 1ns/10ps
`include "dofs_defines.svh"
module dofs_output_select_bench;
    localparam int unsigned HOLD = 20;
    localparam int N = 24;
    localparam int CODES [N] = '{1,2,3,4,5,6,7,8,10,11,13,14,15,16,17,26,28,29,30,31,32,33,36,37};
    localparam int BITS [N] = '{29,28,27,26,25,24,23,22,19,18,13,12,11,10,9,8,7,6,5,4,3,2,1,0};
    localparam int VC [4] = '{23,24,25,34};
    logic clk_sys, rst, fastPulseMode, fastPulseTrain, encIndexPin;
    logic [`DOFS_SEL_W-1:0] selRelay1, selRelay2, selCollector, selFast;
    dofs_pkg::dofs_status_t status;
    dofs_pkg::dofs_virt_t virtBits;
    dofs_pkg::dofs_card_t cardOut;
    logic relay1, relay2, collectorOut, fastOut, holdOn;
    logic [3:0] seen;
    int fails = 0, nTests = 0, cycles = 0, n;
    // ****************************************************************
    // design, far side, clock
    // ****************************************************************
    dofs_output_select #(.INDEX_HOLD_CYC(HOLD)) dut (.clk_sys(clk_sys), .rst(rst),
        .selRelay1(selRelay1), .selRelay2(selRelay2), .selCollector(selCollector),
        .selFast(selFast), .fastPulseMode(fastPulseMode), .fastPulseTrain(fastPulseTrain),
        .status(status), .virtBits(virtBits), .cardOut(cardOut), .encIndexPin(encIndexPin),
        .relay1(relay1), .relay2(relay2), .collectorOut(collectorOut),
        .fast_pulse_terminal(fastOut), .indexHoldActive(holdOn));
    dofs_relay_bank far (.clk_sys(clk_sys), .terms({fastOut, collectorOut, relay2, relay1}),
        .seen(seen));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    // inputs move 1 ns after the edge so no race with the sampling edge
    task step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : step
    task chk(input logic got, input logic exp);
        nTests++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task setAll(input int c);
        {selRelay1, selRelay2, selCollector, selFast} = {4{6'(c)}};
    endtask : setAll
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    // hang guard: the tests need well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop;
        end
    end
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        rst = 1'b1;
        setAll(0);
        {fastPulseMode, fastPulseTrain, encIndexPin} = 3'h0;
        status = '0;
        virtBits = '0;
        cardOut = '0;
        step(5);
        rst = 1'b0;
        selRelay2 = 6'h05;
        // each condition alone turns its code on, everything else keeps it off
        for (int i = 0; i < N; i++) begin
            {selRelay1, selCollector} = {2{6'(CODES[i])}};
            status = dofs_pkg::dofs_status_t'(30'h1 << BITS[i]);
            step(3);
            chk(relay1, 1'b1);
            chk(collectorOut, 1'b1);
            chk(relay2, 1'(BITS[i] == 25));
            chk(seen[1], 1'(BITS[i] == 25));
            chk(seen[0], 1'b1);
            status = ~status;
            step(3);
            chk(relay1, 1'b0);
            chk(collectorOut, 1'b0);
        end
        // combined conditions: ready on relay1, zero speed on collector
        {selRelay1, selCollector} = {6'h0C, 6'h09};
        for (int j = 0; j < 16; j++) begin
            status = '0;
            {status.mainPowerOk, status.ctrlPowerOk, status.protectionActive} = 3'(j >> 1);
            status.readyToRun = 1'(j);
            {status.outFreqZero, status.refFreqZero} = 2'(j);
            step(3);
            chk(relay1, 1'(j == 13));
            chk(collectorOut, 1'(j % 4 == 3));
        end
        // virtual bits belong to their own terminal
        for (int k = 0; k < 8; k++) begin
            setAll(VC[k / 2]);
            virtBits = dofs_pkg::dofs_virt_t'(16'((k % 2 ? 5'hA : 5'h5) << (4 * (3 - k / 2))));
            step(3);
            chk(relay1, 1'(k % 2 == 0));
            chk(relay2, 1'(k % 2));
            chk(collectorOut, 1'(k % 2 == 0));
            chk(fastOut, 1'(k % 2));
        end
        cardOut = 2'h2;
        for (int c = 41; c < 43; c++) begin
            setAll(c);
            step(3);
            chk(relay1, 1'(c == 41));
        end
        // fast terminal as level, then as pulse train
        setAll(5);
        status = '0;
        status.fault = 1'b1;
        step(3);
        chk(fastOut, 1'b1);
        fastPulseMode = 1'b1;
        for (int i = 0; i < 6; i++) begin
            fastPulseTrain = 1'(i);
            step(1);
            chk(fastOut, 1'(i));
        end
        fastPulseMode = 1'b0;
        // with every condition high, unused codes stay off
        status = '1;
        virtBits = '1;
        cardOut = '1;
        for (int c = 0; c < 64; c++) begin
            if (c == 0 || (c > 17 && c < 23) || c == 35 || (c > 37 && c < 41) || c > 42) begin
                setAll(c);
                step(3);
                chk(relay1 | relay2 | collectorOut | fastOut, 1'b0);
            end
        end
        // index pulse on two terminals at once
        setAll(27);
        status = '0;
        encIndexPin = 1'b1;
        step(4);
        encIndexPin = 1'b0;
        n = 0;
        while (relay1 !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        chk(holdOn, 1'b1);
        n = 0;
        while (relay1 === 1'b1 && n < 100) begin
            chk(relay2, 1'b1);
            step(1);
            n++;
        end
        chk(1'(n == HOLD), 1'b1);
        chk(holdOn, 1'b0);
        report_and_stop;
    end
endmodule : dofs_output_select_bench

bind dofs_output_select dofs_output_select_properties #(.INDEX_HOLD_CYC(INDEX_HOLD_CYC)) props (
    .clk_sys(clk_sys), .rst(rst), .selRelay1(selRelay1), .selRelay2(selRelay2),
    .selCollector(selCollector), .selFast(selFast), .fastPulseMode(fastPulseMode),
    .fastPulseTrain(fastPulseTrain), .status(status), .virtBits(virtBits),
    .encIndexPin(encIndexPin), .relay1(relay1), .relay2(relay2), .collectorOut(collectorOut),
    .fast_pulse_terminal(fast_pulse_terminal), .indexHoldActive(indexHoldActive));

// ---- tb/dofs_output_select_properties.sv ----
// port assertions for the digital output function selector
`timescale 1ns/10ps
`include "dofs_defines.svh"
module dofs_output_select_properties #(
    parameter int unsigned INDEX_HOLD_CYC = 20
) (
    input wire logic                   clk_sys,
    input wire logic                   rst,
    input wire logic [`DOFS_SEL_W-1:0] selRelay1,
    input wire logic [`DOFS_SEL_W-1:0] selRelay2,
    input wire logic [`DOFS_SEL_W-1:0] selCollector,
    input wire logic [`DOFS_SEL_W-1:0] selFast,
    input wire logic                   fastPulseMode,
    input wire logic                   fastPulseTrain,
    input wire dofs_pkg::dofs_status_t status,
    input wire dofs_pkg::dofs_virt_t   virtBits,
    input wire logic                   encIndexPin,
    input wire logic                   relay1,
    input wire logic                   relay2,
    input wire logic                   collectorOut,
    input wire logic                   fast_pulse_terminal,
    input wire logic                   indexHoldActive
);
    // ****************************************************************
    // helper and properties
    // ****************************************************************
    logic [31:0] holdCnt;
    // length of the running hold; a retrigger inside a hold lengthens it, so index_len_a fails
    always_ff @(posedge clk_sys) begin
        if (rst || !indexHoldActive) holdCnt <= 32'h0;
        else holdCnt <= holdCnt + 32'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence fastLevelSel;
        !fastPulseMode && selFast == 6'h05;
    endsequence
    codeZero_off_a: assert property (selRelay1 == 6'h00 |=> !relay1)
        else $error("terminal on with code zero");
    fault_pass_a: assert property (selRelay2 == 6'h05 |=> relay2 == $past(status.fault))
        else $error("fault code level wrong");
    zero_speed_a: assert property (selCollector == 6'h09 |=>
        collectorOut == ($past(status.outFreqZero) && $past(status.refFreqZero)))
        else $error("zero speed level wrong");
    ready_run_a: assert property (selRelay1 == 6'h0C |=> relay1 == ($past(status.mainPowerOk)
        && $past(status.ctrlPowerOk) && !$past(status.protectionActive) && $past(status.readyToRun)))
        else $error("ready level wrong");
    reserved_off_a: assert property (selCollector inside {[6'h12:6'h16], 6'h23,
        [6'h26:6'h28], [6'h2B:6'h3F]} |=> !collectorOut) else $error("reserved code drives on");
    virt_term_a: assert property (selRelay2 == 6'h17 |=> relay2 == $past(virtBits.modbus[1]))
        else $error("virtual bit level wrong");
    fast_level_a: assert property (fastLevelSel ##1 fastLevelSel |=>
        fast_pulse_terminal == $past(status.fault, 2)) else $error("fast level wrong");
    fast_pulse_a: assert property (fastPulseMode ##1 fastPulseMode |=>
        fast_pulse_terminal == $past(fastPulseTrain)) else $error("pulse train not passed");
    index_rise_a: assert property ($rose(encIndexPin) |-> ##[4:6] indexHoldActive)
        else $error("index hold did not start");
    index_len_a: assert property ($fell(indexHoldActive) |-> holdCnt == INDEX_HOLD_CYC)
        else $error("index hold length wrong");
    index_term_a: assert property (selRelay1 == 6'h1B |=> relay1 == $past(indexHoldActive))
        else $error("index code level wrong");
endmodule : dofs_output_select_properties

// ---- tb/dofs_relay_bank.sv ----
// far side model: relay coils and controller inputs latch the terminal levels
`timescale 1ns/10ps
module dofs_relay_bank (
    input  wire logic       clk_sys,
    input  wire logic [3:0] terms,
    output logic [3:0]      seen
);
    // a coil only reacts on the clock, so glitches between edges are not seen
    always_ff @(posedge clk_sys) begin
        seen <= terms;
    end
endmodule : dofs_relay_bank
